// >>> design/cmd_pkg.sv
// constants for the accumulator-velocity and indexed user variable commands
// What this block does
// - rotate-left code 50: decreasing direction, accumulator speed
// - rotate-right code 51: increasing direction, accumulator speed
// - rotate: velocity mode first, then parameter 2
// - accumulator velocity passed raw, unconverted
// - code 55: frame value stored at var[x]
// - get-indexed (byte 38 hex): accumulator loads var[x]
// - code 39 hex: accumulator copied into var[x]
// - x outside 0..255: indexed access skipped, reply still sent
package cmd_pkg;
  localparam int          FRAME_BYTES   = 9;
  localparam logic [3:0]  LAST_BYTE_IDX = 4'h8;
  localparam logic [3:0]  INSTR_IDX     = 4'h1;
  localparam logic [3:0]  VALUE_FIRST   = 4'h4;
  localparam logic [7:0]  OP_ROT_LEFT   = 8'h32;
  localparam logic [7:0]  OP_ROT_RIGHT  = 8'h33;
  localparam logic [7:0]  OP_SET_IDX    = 8'h37;
  localparam logic [7:0]  OP_GET_IDX    = 8'h38;
  localparam logic [7:0]  OP_ACC_IDX    = 8'h39;
  localparam logic [7:0]  STATUS_OK     = 8'h64;
  localparam logic [7:0]  PARAM_TGT_VEL = 8'h02;
  localparam int          VAR_COUNT     = 256;
  localparam logic [31:0] ACC_RESET     = 32'h0000_0000;
  localparam logic [31:0] X_RESET       = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_VEL   = 3'b001,
    ST_REPLY = 3'b011,
    ST_RD    = 3'b010,
    ST_RDW   = 3'b110
  } state_type;
endpackage

// >>> design/user_var_if.sv
// carrier between the interpreter and the user variable bank
`timescale 1ns/1ps
`default_nettype none
interface user_var_if;
  logic        wr_en;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// >>> design/user_var_bank.sv
// bank of 256 user variables, registered read
`timescale 1ns/1ps
`default_nettype none
module user_var_bank (
  input  wire logic  mclk,
  user_var_if.bank   vars
);
  import cmd_pkg::*;

  logic [31:0] mem [VAR_COUNT];
  logic [31:0] rdata_r;

  // write port and registered read of the selected entry
  always_ff @(posedge mclk) begin
    if (vars.wr_en) begin
      mem[vars.addr] <= vars.wdata;
    end
    rdata_r <= mem[vars.addr];
  end

  assign vars.rdata = rdata_r;
endmodule
`default_nettype wire

// >>> design/accum_var_cmds.sv
// interpreter for rotate-from-accumulator and indexed user variable commands
`timescale 1ns/1ps
`default_nettype none
module accum_var_cmds (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output var  logic        byte_ready,
  input  wire logic        acc_load,
  input  wire logic [31:0] acc_in,
  input  wire logic        x_load,
  input  wire logic [31:0] x_in,
  output var  logic [31:0] acc,
  output var  logic [31:0] x_reg,
  output var  logic        vel_mode_set,
  output var  logic        dir_right,
  output var  logic        param_wr,
  output var  logic [7:0]  param_num,
  output var  logic [31:0] param_val,
  output var  logic        reply_valid,
  output var  logic [7:0]  reply_status,
  output var  logic [7:0]  reply_instr,
  output var  logic        chk_err
);
  import cmd_pkg::*;

  // carrier and bank of the user variables
  user_var_if vars ();

  user_var_bank u_bank (
    .mclk (mclk),
    .vars (vars.bank)
  );

  // true when a signed x selects an existing user variable
  function automatic logic idx_ok(input logic [31:0] x);
    return (x[31:8] == 24'h00_0000);
  endfunction

  state_type   state_r, state_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic [7:0]  sum_r, sum_nxt;
  logic [7:0]  instr_r, instr_nxt;
  logic [31:0] val_r, val_nxt;
  logic [31:0] acc_r, acc_nxt;
  logic [31:0] x_r, x_nxt;
  logic        mode_r, mode_nxt;
  logic        dir_r, dir_nxt;
  logic        pwr_r, pwr_nxt;
  logic [31:0] pval_r, pval_nxt;
  logic        rep_r, rep_nxt;
  logic        err_r, err_nxt;
  logic        take;
  logic        frame_last;
  logic        frame_good;

  // a byte is taken only while idle and ready; the ninth one is the sum
  assign take       = byte_valid && byte_ready && (state_r == ST_IDLE);
  assign frame_last = take && (cnt_r == LAST_BYTE_IDX);
  assign frame_good = frame_last && (byte_data == sum_r);

  // frame assembly, command execution and reply sequencing
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    sum_nxt    = sum_r;
    instr_nxt  = instr_r;
    val_nxt    = val_r;
    acc_nxt    = acc_load ? acc_in : acc_r;
    x_nxt      = x_load ? x_in : x_r;
    mode_nxt   = 1'b0;
    dir_nxt    = dir_r;
    pwr_nxt    = 1'b0;
    pval_nxt   = pval_r;
    rep_nxt    = 1'b0;
    err_nxt    = 1'b0;
    vars.wr_en = 1'b0;
    vars.addr  = x_r[7:0];
    vars.wdata = val_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take && !frame_last) begin
          cnt_nxt = cnt_r + 4'h1;
          sum_nxt = sum_r + byte_data;
          if (cnt_r == INSTR_IDX) begin
            instr_nxt = byte_data;
          end
          if (cnt_r >= VALUE_FIRST) begin
            val_nxt = {val_r[23:0], byte_data}; // byte 3 arrives first
          end
        end
        if (frame_last) begin
          cnt_nxt = 4'h0;
          sum_nxt = 8'h00;
          err_nxt = !frame_good;
        end
        if (frame_good) begin
          unique case (instr_r)
            OP_ROT_LEFT, OP_ROT_RIGHT: begin
              mode_nxt  = 1'b1;
              dir_nxt   = (instr_r == OP_ROT_RIGHT);
              state_nxt = ST_VEL;
            end
            OP_SET_IDX: begin
              vars.wr_en = idx_ok(x_r);
              state_nxt  = ST_REPLY;
            end
            OP_ACC_IDX: begin
              vars.wr_en = idx_ok(x_r);
              vars.wdata = acc_r;
              state_nxt  = ST_REPLY;
            end
            OP_GET_IDX: begin
              state_nxt = idx_ok(x_r) ? ST_RD : ST_REPLY;
            end
            default: begin
              state_nxt = ST_IDLE; // foreign command, left to others
            end
          endcase
        end
      end
      ST_VEL: begin
        pwr_nxt   = 1'b1;
        pval_nxt  = acc_r;
        state_nxt = ST_REPLY;
      end
      ST_RD: begin
        state_nxt = ST_RDW;
      end
      ST_RDW: begin
        acc_nxt   = vars.rdata;
        state_nxt = ST_REPLY;
      end
      ST_REPLY: begin
        rep_nxt   = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      sum_r   <= 8'h00;
      instr_r <= 8'h00;
      val_r   <= 32'h0000_0000;
      acc_r   <= ACC_RESET;
      x_r     <= X_RESET;
      mode_r  <= 1'b0;
      dir_r   <= 1'b0;
      pwr_r   <= 1'b0;
      pval_r  <= 32'h0000_0000;
      rep_r   <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sum_r   <= sum_nxt;
      instr_r <= instr_nxt;
      val_r   <= val_nxt;
      acc_r   <= acc_nxt;
      x_r     <= x_nxt;
      mode_r  <= mode_nxt;
      dir_r   <= dir_nxt;
      pwr_r   <= pwr_nxt;
      pval_r  <= pval_nxt;
      rep_r   <= rep_nxt;
      err_r   <= err_nxt;
    end
  end

  // a flop stands behind every output, the fixed codes included
  always_ff @(posedge mclk) begin
    if (rst) begin
      byte_ready   <= 1'b0;
      param_num    <= 8'h00;
      reply_status <= 8'h00;
    end else begin
      byte_ready   <= (state_nxt == ST_IDLE);
      param_num    <= PARAM_TGT_VEL;
      reply_status <= STATUS_OK;
    end
  end

  assign acc          = acc_r;
  assign x_reg        = x_r;
  assign vel_mode_set = mode_r;
  assign dir_right    = dir_r;
  assign param_wr     = pwr_r;
  assign param_val    = pval_r;
  assign reply_valid  = rep_r;
  assign reply_instr  = instr_r;
  assign chk_err      = err_r;

  // checks of the command rules and covers of the main paths
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  rot_left_a: assert property (frame_good && instr_r == OP_ROT_LEFT
    |=> vel_mode_set && !dir_right)
    else $error("rotate left did not select decreasing direction");
  rot_right_a: assert property (frame_good && instr_r == OP_ROT_RIGHT
    |=> vel_mode_set && dir_right)
    else $error("rotate right did not select increasing direction");
  mode_then_vel_a: assert property (vel_mode_set
    |-> !param_wr ##1 (param_wr && param_num == 8'h02))
    else $error("velocity write did not follow mode switch");
  vel_raw_a: assert property (param_wr
    |-> param_val == $past(acc_r))
    else $error("velocity differs from accumulator");
  set_store_a: assert property (vars.wr_en && instr_r == OP_SET_IDX
    |-> vars.wdata == val_r)
    else $error("set indexed stored wrong value");
  get_load_a: assert property (state_r == ST_RDW && !acc_load
    ##1 1'b1 |-> acc_r == $past(vars.rdata))
    else $error("get indexed did not load accumulator");
  acc_copy_a: assert property (vars.wr_en && instr_r == OP_ACC_IDX
    |-> vars.wdata == acc_r && vars.addr == x_r[7:0])
    else $error("accumulator copy wrong");
  index_guard_a: assert property ((vars.wr_en || state_r == ST_RD)
    |-> x_r[31:8] == 24'h00_0000)
    else $error("out of range index used");
  reply_ok_a: assert property (frame_good && (instr_r == OP_SET_IDX
    || instr_r == OP_ACC_IDX) |=> !reply_valid ##1 reply_valid)
    else $error("reply missing after indexed store");
  chk_bad_a: assert property (frame_last && !frame_good
    |=> chk_err && !reply_valid && state_r == ST_IDLE)
    else $error("bad checksum not flagged");

  rot_seen_c: cover property (param_wr ##1 reply_valid);
  get_seen_c: cover property (state_r == ST_RDW ##1 reply_valid);
  err_seen_c: cover property (chk_err);
endmodule
`default_nettype wire

// >>> dv/host_model.sv
// host side model that sends nine-byte command frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  input  wire logic       byte_ready,
  output var  logic       byte_valid,
  output var  logic [7:0] byte_data
);
  // idle lines at time zero
  initial begin
    byte_valid = 1'b0;
    byte_data  = 8'h00;
  end

  // one frame, bytes held until taken; bad spoils the checksum
  task automatic send(input logic [7:0] instr, input logic [31:0] val,
                      input bit bad);
    logic [7:0] f [9];
    f = '{8'h01, instr, 8'h00, 8'h00, val[31:24], val[23:16],
          val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    f[8] = f[8] + 8'(bad);
    for (int i = 0; i < 9; i++) begin
      byte_valid = 1'b1;
      byte_data  = f[i];
      do @(negedge mclk); while (byte_ready !== 1'b1);
      @(posedge mclk);
      #1;
    end
    byte_valid = 1'b0;
    byte_data  = ~f[8]; // released data does not keep the last byte
  endtask
endmodule
`default_nettype wire

// >>> dv/accum_velocity_indexed_var_cmds_tb.sv
// self-checking bench for the accumulator and indexed variable commands
`timescale 1ns/1ps
`default_nettype none
module accum_velocity_indexed_var_cmds_tb;
  import cmd_pkg::*;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic        byte_valid, byte_ready, acc_load, x_load, vel_mode_set;
  logic        dir_right, param_wr, reply_valid, chk_err, pd;
  logic [7:0]  byte_data, param_num, reply_status, reply_instr, rs, ri, pn;
  logic [31:0] acc_in, x_in, acc, x_reg, param_val, pv, m_acc, m_x;
  logic [31:0] mv [256];
  bit          known [256];
  logic [7:0]  ops [5] = '{OP_ROT_LEFT, OP_ROT_RIGHT, OP_SET_IDX,
                           OP_GET_IDX, OP_ACC_IDX};
  int          n_mismatch, cmp_count, cyc, vmc, pwc, rvc, cec;

  always #2.5 mclk = ~mclk;

  accum_var_cmds dut (.mclk(mclk), .rst(rst), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_ready(byte_ready), .acc_load(acc_load),
    .acc_in(acc_in), .x_load(x_load), .x_in(x_in), .acc(acc),
    .x_reg(x_reg), .vel_mode_set(vel_mode_set), .dir_right(dir_right),
    .param_wr(param_wr), .param_num(param_num), .param_val(param_val),
    .reply_valid(reply_valid), .reply_status(reply_status),
    .reply_instr(reply_instr), .chk_err(chk_err));

  host_model host (.mclk(mclk), .byte_ready(byte_ready),
    .byte_valid(byte_valid), .byte_data(byte_data));

  // capture pulses with their cycle numbers; cut a hang short
  always @(posedge mclk) begin
    if (vel_mode_set === 1'b1) vmc = cyc;
    if (param_wr === 1'b1) begin
      pwc = cyc;
      pv  = param_val;
      pn  = param_num;
      pd  = dir_right;
    end
    if (reply_valid === 1'b1) begin
      rvc = cyc;
      rs  = reply_status;
      ri  = reply_instr;
    end
    if (chk_err === 1'b1) cec = cyc;
    cyc = cyc + 1;
    if (cyc > 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one frame against the model; e tags the cycle after the checksum edge
  task automatic run(input logic [7:0] op, input logic [31:0] val,
                     input bit bad);
    bit good;
    bit listed;
    int e;
    int lat;
    good   = !bad && m_x[31:8] == 24'h0;
    listed = op == OP_ROT_LEFT || op == OP_ROT_RIGHT || op == OP_SET_IDX
             || op == OP_GET_IDX || op == OP_ACC_IDX;
    lat    = (op == OP_ROT_LEFT || op == OP_ROT_RIGHT) ? 2
             : (good && op == OP_GET_IDX) ? 3 : 1;
    vmc = -1;
    pwc = -1;
    rvc = -1;
    cec = -1;
    host.send(op, val, bad);
    e = cyc;
    repeat (6) @(posedge mclk);
    #1;
    if (bad) begin
      chk("no reply", 32'hffff_ffff, rvc);
      chk("chk_err", 32'(e), 32'(cec));
    end else if (!listed) begin
      chk("foreign reply", 32'hffff_ffff, rvc);
    end else begin
      chk("reply cycle", 32'(e + lat), 32'(rvc));
      chk("reply_status", 32'(STATUS_OK), 32'(rs));
      chk("reply_instr", 32'(op), 32'(ri));
      if (op == OP_ROT_LEFT || op == OP_ROT_RIGHT) begin
        chk("dir_right", 32'(op == OP_ROT_RIGHT), 32'(pd));
        chk("param_val", m_acc, pv);
        chk("param_num", 32'(PARAM_TGT_VEL), 32'(pn));
        chk("mode first", 32'(vmc + 1), 32'(pwc));
        chk("reply after", 32'(pwc + 1), 32'(rvc));
      end
    end
    if (good && op == OP_SET_IDX) mv[m_x[7:0]] = val;
    if (good && op == OP_ACC_IDX) mv[m_x[7:0]] = m_acc;
    if (good && (op == OP_SET_IDX || op == OP_ACC_IDX)) known[m_x[7:0]] = 1;
    if (good && op == OP_GET_IDX) m_acc = mv[m_x[7:0]];
    chk("acc", m_acc, acc);
    chk("x_reg", m_x, x_reg);
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // main sequence: each code in turn, random operands and indexes
  initial begin
    logic [7:0] op;
    void'($urandom(51));
    {acc_load, x_load, acc_in, x_in} = '0;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    for (int i = 0; i < 60; i++) begin
      op = (i % 11 == 10) ? 8'h2a : ops[i % 5]; // 2a decodes to nothing
      acc_load = 1'b1;
      x_load   = 1'b1;
      acc_in   = $urandom;
      x_in     = (i % 6 == 5) ? ((i % 12 == 5) ? 32'h100 : 32'hffff_ffff)
                              : 32'($urandom_range(3));
      @(posedge mclk);
      #1;
      {acc_load, x_load} = 2'b00;
      m_acc = acc_in;
      m_x   = x_in;
      if (op == OP_GET_IDX && m_x[31:8] == 24'h0 && !known[m_x[7:0]])
        op = OP_SET_IDX;
      run(op, $urandom, i % 7 == 6);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
